// ### design/fast_timer_cfg.svh
// Register offsets, field positions, reset values and timing counts of the fast timer
`ifndef FAST_TIMER_CFG_SVH
`define FAST_TIMER_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets on APB
// ---------------------------------------------------------------
`define OFS_TIMER_CONTROL 8'h00
`define OFS_CHANNEL_B_CONTROL 8'h04
`define OFS_GLOBAL_TIMER_CONTROL 8'h08
`define OFS_PLL_CONTROL_STATUS 8'h0C
`define OFS_COUNTER_VALUE 8'h10
`define OFS_COMPARE_A_VALUE 8'h14
`define OFS_COMPARE_B_VALUE 8'h18
`define OFS_COMPARE_TOP_VALUE 8'h1C
`define OFS_TIMER_FLAG_REGISTER 8'h20
`define OFS_TIMER_MASK_REGISTER 8'h24

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TC_CLEAR_ON_TOP 7
`define TC_PWM_A_ENABLE 6
`define TC_MODE_A_HI 5
`define TC_MODE_A_LO 4
`define TC_CLOCK_SEL_HI 3
`define TC_CLOCK_SEL_LO 0
`define CB_PWM_B_ENABLE 6
`define CB_MODE_B_HI 5
`define CB_MODE_B_LO 4
`define GT_PRESCALER_RESET 1
`define PL_ASYNC_CLOCK_SELECT 2
`define FL_COMPARE_A 2
`define FL_COMPARE_B 1
`define FL_OVERFLOW 0

// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_FLAGS 3'h0
`define RST_PRESCALER 14'h0000
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
`define COUNT_PWM_SET 8'h01
`define FLAG_MASK 8'h07

`endif

// ### design/fast_timer_pkg.sv
// Types shared by the fast timer
package fast_timer_pkg;

	// Compare output action selected per channel
	typedef enum logic [1:0] {
		out_off = 2'b00,
		out_toggle = 2'b01,
		out_clear = 2'b10,
		out_set = 2'b11
	} out_mode_t;

	// Prescaler clock select code
	typedef logic [3:0] clock_sel_t;

endpackage

// ### design/fast_timer.sv
// 8-bit fast timer/counter with prescaler, three compares and APB registers
// Operation
// - 8-bit counter with own prescaler select
// - Prescaler runs on system or fast clock
// - Stop, then divide by 1 to 16384
// - Prescaler reset bit clears the prescaler
// - Fast peripheral clock 64 or 32 MHz
// - Written values pass input synchronizer stage
// - Control and compare registers read back immediately
// - Counter and flags readback delayed by stages
// - Three flags, enables in mask register
// - Normal mode compares against all three
// - Compare A drives output A, flag A
// - Compare B drives output B, flag B
// - Compare top holds counter maximum value
// - Normal mode overflow on FF to 00
// - PWM overflow on FF or top to 00
// - Normal mode inverted outputs stay disconnected
// - PWM counts zero up to top
// - PWM toggle mode gives two complementary output pairs
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fast_timer_cfg.svh"

module fast_timer
	import fast_timer_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_peripheral_clock,
	input wire logic [2:0] vector_taken,
	output logic [2:0] flag_request,
	output logic compare_a_output,
	output logic compare_a_output_n,
	output logic compare_b_output,
	output logic compare_b_output_n
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------

	// Prescaler tap: stop, undivided, or 2^(sel-1) division
	function automatic logic tap_tick(input clock_sel_t sel, input logic [13:0] pre, input logic src);
		logic hit;
		hit = 1'b0;
		if (sel == 4'h0) begin
			hit = 1'b0;
		end else if (sel == 4'h1) begin
			hit = src;
		end else begin
			hit = src && ((pre | ~((14'h0001 << (sel - 4'h1)) - 14'h0001)) == 14'h3FFF);
		end
		return hit;
	endfunction

	// Address is one of the mapped registers
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= `OFS_TIMER_MASK_REGISTER);
	endfunction

	// ---------------------------------------------------------------
	// Register file and APB decode
	// ---------------------------------------------------------------
	logic [7:0] timer_control_q;
	logic [7:0] channel_b_control_q;
	logic [7:0] global_timer_control_q;
	logic [7:0] pll_control_status_q;
	logic [7:0] compare_a_value_q;
	logic [7:0] compare_b_value_q;
	logic [7:0] compare_top_value_q;
	logic [7:0] timer_mask_register_q;
	logic [7:0] counter_value_q;
	logic [2:0] flags_q;
	logic [7:0] count_read_q;
	logic [2:0] flags_read_q;
	logic sync_psr_q;
	logic access;
	logic wr;
	logic [7:0] wbyte;

	assign access = psel && penable && pready;
	assign wr = access && pwrite && is_mapped(paddr);
	assign wbyte = pwdata[7:0];

	// Zero-wait answer: ready in first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !is_mapped(paddr);
		end
	end

	// Read data captured in setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && pwrite) begin
			// Writes return zero data
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				`OFS_TIMER_CONTROL: prdata[7:0] <= timer_control_q;
				`OFS_CHANNEL_B_CONTROL: prdata[7:0] <= channel_b_control_q;
				`OFS_GLOBAL_TIMER_CONTROL: prdata[7:0] <= global_timer_control_q;
				`OFS_PLL_CONTROL_STATUS: prdata[7:0] <= pll_control_status_q;
				`OFS_COUNTER_VALUE: prdata[7:0] <= count_read_q;
				`OFS_COMPARE_A_VALUE: prdata[7:0] <= compare_a_value_q;
				`OFS_COMPARE_B_VALUE: prdata[7:0] <= compare_b_value_q;
				`OFS_COMPARE_TOP_VALUE: prdata[7:0] <= compare_top_value_q;
				`OFS_TIMER_FLAG_REGISTER: prdata[2:0] <= flags_read_q;
				`OFS_TIMER_MASK_REGISTER: prdata[2:0] <= timer_mask_register_q[2:0];
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Software-written control and compare registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_q <= `RST_BYTE;
			channel_b_control_q <= `RST_BYTE;
			pll_control_status_q <= `RST_BYTE;
			compare_a_value_q <= `RST_BYTE;
			compare_b_value_q <= `RST_BYTE;
			compare_top_value_q <= `RST_BYTE;
			timer_mask_register_q <= `RST_BYTE;
		end else if (wr) begin
			unique case (paddr)
				`OFS_TIMER_CONTROL: timer_control_q <= wbyte;
				`OFS_CHANNEL_B_CONTROL: channel_b_control_q <= wbyte & 8'h70;
				`OFS_PLL_CONTROL_STATUS: pll_control_status_q <= wbyte & 8'h04;
				`OFS_COMPARE_A_VALUE: compare_a_value_q <= wbyte;
				`OFS_COMPARE_B_VALUE: compare_b_value_q <= wbyte;
				`OFS_COMPARE_TOP_VALUE: compare_top_value_q <= wbyte;
				`OFS_TIMER_MASK_REGISTER: timer_mask_register_q <= wbyte & `FLAG_MASK;
				default: ;
			endcase
		end
	end

	// Prescaler reset bit: set by write, cleared once applied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_timer_control_q <= `RST_BYTE;
		end else if (wr && paddr == `OFS_GLOBAL_TIMER_CONTROL) begin
			global_timer_control_q <= wbyte;
		end else if (sync_psr_q) begin
			global_timer_control_q[`GT_PRESCALER_RESET] <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Input synchronization stage
	// ---------------------------------------------------------------
	logic [7:0] sync_tc_q;
	logic [7:0] sync_cb_q;
	logic sync_async_q;
	logic [7:0] sync_a_q;
	logic [7:0] sync_b_q;
	logic [7:0] sync_top_q;
	logic sync_cnt_wr_q;
	logic [7:0] sync_cnt_val_q;

	// Counter logic sees register values one cycle late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_tc_q <= `RST_BYTE;
			sync_cb_q <= `RST_BYTE;
			sync_async_q <= 1'b0;
			sync_psr_q <= 1'b0;
			sync_a_q <= `RST_BYTE;
			sync_b_q <= `RST_BYTE;
			sync_top_q <= `RST_BYTE;
			sync_cnt_wr_q <= 1'b0;
			sync_cnt_val_q <= `RST_BYTE;
		end else begin
			sync_tc_q <= timer_control_q;
			sync_cb_q <= channel_b_control_q;
			sync_async_q <= pll_control_status_q[`PL_ASYNC_CLOCK_SELECT];
			sync_psr_q <= global_timer_control_q[`GT_PRESCALER_RESET] && !sync_psr_q;
			sync_a_q <= compare_a_value_q;
			sync_b_q <= compare_b_value_q;
			sync_top_q <= compare_top_value_q;
			sync_cnt_wr_q <= wr && paddr == `OFS_COUNTER_VALUE;
			sync_cnt_val_q <= wbyte;
		end
	end

	// ---------------------------------------------------------------
	// Clock source and prescaler
	// ---------------------------------------------------------------
	logic fclk_s1_q;
	logic fclk_s2_q;
	logic fclk_s3_q;
	logic [13:0] prescale_q;
	logic src_tick;
	logic tick;

	// Two-stage synchronizer, then edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fclk_s1_q <= 1'b0;
			fclk_s2_q <= 1'b0;
			fclk_s3_q <= 1'b0;
		end else begin
			fclk_s1_q <= fast_peripheral_clock;
			fclk_s2_q <= fclk_s1_q;
			fclk_s3_q <= fclk_s2_q;
		end
	end

	// Source edge: every cycle, or fast clock rising edge
	assign src_tick = sync_async_q ? (fclk_s2_q && !fclk_s3_q) : 1'b1;
	assign tick = tap_tick(clock_sel_t'(sync_tc_q[`TC_CLOCK_SEL_HI:`TC_CLOCK_SEL_LO]), prescale_q, src_tick);

	// Free-running prescaler, cleared by its reset bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_q <= `RST_PRESCALER;
		end else if (sync_psr_q) begin
			prescale_q <= `RST_PRESCALER;
		end else if (src_tick) begin
			prescale_q <= prescale_q + 14'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Counter, compares and overflow
	// ---------------------------------------------------------------
	logic pwm_a;
	logic pwm_b;
	logic pwm_any;
	logic at_top;
	logic at_max;
	logic wrap;
	logic match_a;
	logic match_b;
	logic [7:0] active_a_q;
	logic [7:0] active_b_q;
	logic [2:0] event_set;

	assign pwm_a = sync_tc_q[`TC_PWM_A_ENABLE];
	assign pwm_b = sync_cb_q[`CB_PWM_B_ENABLE];
	assign pwm_any = pwm_a || pwm_b;
	assign at_top = counter_value_q == sync_top_q;
	assign at_max = counter_value_q == `COUNT_MAX;
	assign wrap = tick && at_top && (pwm_any || sync_tc_q[`TC_CLEAR_ON_TOP]);
	assign match_a = tick && counter_value_q == active_a_q;
	assign match_b = tick && counter_value_q == active_b_q;

	// Overflow on FF to 00, or in PWM also on top to 00
	assign event_set[`FL_OVERFLOW] = tick && (at_max || (pwm_any && at_top));
	assign event_set[`FL_COMPARE_A] = match_a;
	assign event_set[`FL_COMPARE_B] = match_b;

	// Up counter; PWM restarts from bottom after top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value_q <= `COUNT_BOTTOM;
		end else if (sync_cnt_wr_q) begin
			counter_value_q <= sync_cnt_val_q;
		end else if (wrap) begin
			counter_value_q <= `COUNT_BOTTOM;
		end else if (tick) begin
			counter_value_q <= counter_value_q + 8'h01;
		end
	end

	// PWM compares latch at top to avoid glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_a_q <= `RST_BYTE;
			active_b_q <= `RST_BYTE;
		end else if (!pwm_any || wrap) begin
			active_a_q <= sync_a_q;
			active_b_q <= sync_b_q;
		end
	end

	// ---------------------------------------------------------------
	// Flags: set wins over clear
	// ---------------------------------------------------------------
	logic [2:0] sw_clear;

	assign sw_clear = (wr && paddr == `OFS_TIMER_FLAG_REGISTER) ? wbyte[2:0] : 3'h0;

	// Sticky flags, cleared by write one or vector taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= `RST_FLAGS;
		end else begin
			flags_q <= event_set | (flags_q & ~(sw_clear | vector_taken));
		end
	end

	// Output stage for counter and flag readback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_read_q <= `RST_BYTE;
			flags_read_q <= `RST_FLAGS;
		end else begin
			count_read_q <= counter_value_q;
			flags_read_q <= flags_q;
		end
	end

	// Enabled flags presented as requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_request <= `RST_FLAGS;
		end else begin
			flag_request <= flags_q & timer_mask_register_q[2:0];
		end
	end

	// ---------------------------------------------------------------
	// Compare outputs
	// ---------------------------------------------------------------
	logic [1:0] wave_q;
	logic [1:0] pwm_en;
	logic [1:0] match_v;
	out_mode_t mode_v [2];
	logic [1:0] inv_v;

	assign pwm_en = {pwm_b, pwm_a};
	assign match_v = {match_b, match_a};
	assign mode_v[0] = out_mode_t'(sync_tc_q[`TC_MODE_A_HI:`TC_MODE_A_LO]);
	assign mode_v[1] = out_mode_t'(sync_cb_q[`CB_MODE_B_HI:`CB_MODE_B_LO]);

	// One waveform generator per channel
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_wave
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wave_q[ch] <= 1'b0;
				end else if (pwm_en[ch]) begin
					// PWM: action on match, restore when count hits 1
					if (match_v[ch]) begin
						wave_q[ch] <= (mode_v[ch] == out_set);
					end else if (tick && counter_value_q == `COUNT_BOTTOM) begin
						wave_q[ch] <= (mode_v[ch] != out_set);
					end
				end else if (match_v[ch]) begin
					unique case (mode_v[ch])
						out_off: wave_q[ch] <= wave_q[ch];
						out_toggle: wave_q[ch] <= !wave_q[ch];
						out_clear: wave_q[ch] <= 1'b0;
						out_set: wave_q[ch] <= 1'b1;
					endcase
				end
			end
			// Complement only in PWM toggle mode, else off
			assign inv_v[ch] = pwm_en[ch] && mode_v[ch] == out_toggle && !wave_q[ch];
		end
	endgenerate

	// Pins driven from flip-flops; disconnected reads low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_a_output <= 1'b0;
			compare_a_output_n <= 1'b0;
			compare_b_output <= 1'b0;
			compare_b_output_n <= 1'b0;
		end else begin
			compare_a_output <= (mode_v[0] != out_off) && wave_q[0];
			compare_a_output_n <= inv_v[0];
			compare_b_output <= (mode_v[1] != out_off) && wave_q[1];
			compare_b_output_n <= inv_v[1];
		end
	end

endmodule // fast_timer

`default_nettype wire

// ### bench/fast_timer_properties.sv
// Port checker of the fast timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "fast_timer_cfg.svh"
module fast_timer_properties
	import fast_timer_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fast_peripheral_clock,
	input wire logic [2:0] vector_taken,
	input wire logic [2:0] flag_request,
	input wire logic compare_a_output,
	input wire logic compare_a_output_n,
	input wire logic compare_b_output,
	input wire logic compare_b_output_n
);
	logic [7:0] tc_q, cmpa_q;
	logic [2:0] mask_q;
	logic wr_ok, rd_ok, a_tog;
	default clocking dflt @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Committed accesses and the A toggle-pair mode
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	assign rd_ok = psel && penable && pready && !pwrite;
	assign a_tog = tc_q[6] && (tc_q[5:4] == 2'b01);
	// Shadow of configuration written over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_q <= 8'h00;
			cmpa_q <= 8'h00;
			mask_q <= 3'h0;
		end else if (wr_ok) begin
			if (paddr == `OFS_TIMER_CONTROL) tc_q <= pwdata[7:0];
			if (paddr == `OFS_COMPARE_A_VALUE) cmpa_q <= pwdata[7:0];
			if (paddr == `OFS_TIMER_MASK_REGISTER) mask_q <= pwdata[2:0];
		end
	end
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready missing after setup");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready held too long");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_unmapped;
		psel && !penable && (paddr > 8'h24 || paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_upper_zero;
		pready |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	property p_tc_back;
		rd_ok && paddr == `OFS_TIMER_CONTROL |-> prdata[7:0] == tc_q;
	endproperty
	a_tc_back: assert property (p_tc_back) else $error("control readback wrong");
	property p_cmpa_back;
		rd_ok && paddr == `OFS_COMPARE_A_VALUE |-> prdata[7:0] == cmpa_q;
	endproperty
	a_cmpa_back: assert property (p_cmpa_back) else $error("compare A readback wrong");
	property p_masked;
		(flag_request & ~mask_q & ~$past(mask_q)) == 3'h0;
	endproperty
	a_masked: assert property (p_masked) else $error("request on masked flag");
	property p_inv_off;
		!a_tog && !$past(a_tog) && !$past(a_tog, 2) && !$past(a_tog, 3) |-> !compare_a_output_n;
	endproperty
	a_inv_off: assert property (p_inv_off) else $error("inverted A driven");
	property p_pair;
		a_tog && $past(a_tog) && $past(a_tog, 2) && $past(a_tog, 3) |-> compare_a_output_n != compare_a_output;
	endproperty
	a_pair: assert property (p_pair) else $error("A pair not complementary");
endmodule // fast_timer_properties
bind fast_timer fast_timer_properties chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .fast_peripheral_clock, .vector_taken, .flag_request, .compare_a_output,
	.compare_a_output_n, .compare_b_output, .compare_b_output_n);
`default_nettype wire

// ### bench/fast_timer_tb.sv
// Self-checking testbench of the fast timer
`timescale 1ns/1ps
`default_nettype none
`include "fast_timer_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module fast_timer_tb;
	logic pclk, presetn, psel, penable, pwrite, fast_peripheral_clock, pready, pslverr, err;
	logic [7:0] paddr, r0;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] vector_taken, flag_request, m3;
	logic compare_a_output, compare_a_output_n, compare_b_output, compare_b_output_n;
	int seed = 15220;
	int mismatches = 0;
	int n_compared = 0;
	int mdl [int];
	int a, b, ea, eb, ha, han, hb, hbn;
	int ofs [5] = '{0, 20, 24, 28, 36};
	fast_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.fast_peripheral_clock, .vector_taken, .flag_request, .compare_a_output, .compare_a_output_n,
		.compare_b_output, .compare_b_output_n);
	// System clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Fast clock kept running; async mode unused as it runs faster than pclk
	initial begin
		fast_peripheral_clock = 1'b0;
		forever #7.8 fast_peripheral_clock = ~fast_peripheral_clock;
	end
	// One APB transfer, released after pready
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 50) begin
			mismatches++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		apb(1'b1, ad, v);
	endtask
	task automatic rdc(input logic [7:0] ad);
		apb(1'b0, ad, 32'h0000_0000);
	endtask
	// Verdict and end of run
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		summarize();
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		vector_taken = 3'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			rdc(8'(i * 4));
			`CHK("reset value", 32'h0000_0000, rd)
		end
		rdc(8'h28);
		`CHK("unmapped error", 1'b1, err)
		wr(8'h02, $random(seed));
		`CHK("unaligned error", 1'b1, err)
		foreach (ofs[i]) begin
			mdl[ofs[i]] = $random(seed) & ((ofs[i] == 36) ? 7 : 255);
			wr(8'(ofs[i]), $random(seed) & ~((ofs[i] == 36) ? 7 : 255) | mdl[ofs[i]]);
			rdc(8'(ofs[i]));
			`CHK("readback", mdl[ofs[i]], rd)
		end
		// Counting rate per clock select, reads spaced by whole periods
		for (int s = 0; s < 6; s++) begin
			wr(`OFS_TIMER_CONTROL, s);
			wr(`OFS_GLOBAL_TIMER_CONTROL, 32'h0000_0002);
			repeat (4) @(posedge pclk);
			rdc(`OFS_COUNTER_VALUE);
			r0 = rd[7:0];
			repeat (8 * (1 << (s > 0 ? s - 1 : 0)) - 3) @(posedge pclk);
			rdc(`OFS_COUNTER_VALUE);
			`CHK("count step", (s == 0) ? 8'h00 : 8'h08, 8'(rd[7:0] - r0))
		end
		// Reset again mid-run so the waveform state starts known
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`OFS_TIMER_CONTROL);
		`CHK("reset again", 32'h0000_0000, rd)
		// Normal mode: wrap and compare flags, A toggles, B sets
		wr(`OFS_COUNTER_VALUE, 8'hF0);
		wr(`OFS_COMPARE_A_VALUE, 8'hF4);
		wr(`OFS_COMPARE_B_VALUE, 8'hF8);
		wr(`OFS_CHANNEL_B_CONTROL, 8'h30);
		wr(`OFS_TIMER_MASK_REGISTER, 3'h7);
		wr(`OFS_TIMER_FLAG_REGISTER, 3'h7);
		wr(`OFS_TIMER_CONTROL, 8'h11);
		repeat (40) @(posedge pclk);
		wr(`OFS_TIMER_CONTROL, 8'h10); // Stop, keep toggle mode on A
		mdl[32] = 7;
		rdc(`OFS_TIMER_FLAG_REGISTER);
		`CHK("flags", mdl[32], rd)
		`CHK("request", 3'h7, flag_request)
		`CHK("output a", 1'b1, compare_a_output)
		`CHK("output b", 1'b1, compare_b_output)
		m3 = 3'($random(seed));
		wr(`OFS_TIMER_MASK_REGISTER, m3);
		repeat (3) @(posedge pclk);
		`CHK("masked request", m3, flag_request)
		wr(`OFS_TIMER_FLAG_REGISTER, 3'h2);
		mdl[32] = 5;
		rdc(`OFS_TIMER_FLAG_REGISTER);
		`CHK("write one clear", mdl[32], rd)
		vector_taken <= 3'h5;
		@(posedge pclk);
		vector_taken <= 3'h0;
		repeat (3) @(posedge pclk);
		rdc(`OFS_TIMER_FLAG_REGISTER);
		`CHK("vector clear", 32'h0000_0000, rd)
		// Normal mode clear on top: no overflow flag from top
		wr(`OFS_COUNTER_VALUE, 8'h00);
		wr(`OFS_COMPARE_TOP_VALUE, 8'h05);
		wr(`OFS_TIMER_CONTROL, 8'h81);
		repeat (30) @(posedge pclk);
		rdc(`OFS_COUNTER_VALUE);
		`CHK("clear on top", 1'b1, rd[7:0] <= 8'h05)
		rdc(`OFS_TIMER_FLAG_REGISTER);
		`CHK("no top overflow", 32'h0000_0000, rd)
		// PWM with top 9 for toggle, clear and set modes, duty over ten periods
		for (int m = 1; m < 4; m++) begin
			a = 2 + ($unsigned($random(seed)) % 7);
			b = 2 + ($unsigned($random(seed)) % 7);
			wr(`OFS_TIMER_CONTROL, 8'h00);
			wr(`OFS_COMPARE_TOP_VALUE, 8'h09);
			wr(`OFS_COUNTER_VALUE, 8'h00);
			wr(`OFS_COMPARE_A_VALUE, a);
			wr(`OFS_COMPARE_B_VALUE, b);
			wr(`OFS_CHANNEL_B_CONTROL, 8'h40 | (m << 4));
			wr(`OFS_TIMER_FLAG_REGISTER, 3'h7);
			wr(`OFS_TIMER_CONTROL, 8'h41 | (m << 4));
			repeat (40) @(posedge pclk);
			ha = 0;
			han = 0;
			hb = 0;
			hbn = 0;
			repeat (100) begin
				@(posedge pclk);
				ha += (compare_a_output === 1'b1);
				han += (compare_a_output_n === 1'b1);
				hb += (compare_b_output === 1'b1);
				hbn += (compare_b_output_n === 1'b1);
			end
			ea = (m == 3) ? 100 - 10 * a : 10 * a;
			eb = (m == 3) ? 100 - 10 * b : 10 * b;
			`CHK("pwm a high", ea, ha)
			`CHK("pwm a inverted", (m == 1) ? 100 - ea : 0, han)
			`CHK("pwm b high", eb, hb)
			`CHK("pwm b inverted", (m == 1) ? 100 - eb : 0, hbn)
			rdc(`OFS_COUNTER_VALUE);
			`CHK("count within top", 1'b1, rd[7:0] <= 8'h09)
			rdc(`OFS_TIMER_FLAG_REGISTER);
			`CHK("pwm flags", 32'h0000_0007, rd)
		end
		summarize();
	end
endmodule // fast_timer_tb
`default_nettype wire
